// ---- core/bpm_regs_defs.vh ----
`ifndef BPM_REGS_DEFS_VH
`define BPM_REGS_DEFS_VH

// register addresses
`define BPM_ADDR_SHORT_DELAY_EFF_A    16'h1f42
`define BPM_ADDR_ENERGY_CURVE_EFF_A   16'h1f44
`define BPM_ADDR_SHORT_TRIP_EFF       16'h1f45
`define BPM_ADDR_INTERMIT_A           16'h1f48
`define BPM_ADDR_SHORT_DELAY_ESET_A   16'h1f4a
`define BPM_ADDR_ENERGY_CURVE_ESET_A  16'h1f4c
`define BPM_ADDR_SHORT_TRIP_ESET_A    16'h1f4d
`define BPM_ADDR_SHORT_DELAY_B        16'h1f50
`define BPM_ADDR_ENERGY_CURVE_B       16'h1f52
`define BPM_ADDR_SHORT_TRIP_B         16'h1f53
`define BPM_ADDR_INTERMIT_B           16'h1f54
`define BPM_ADDR_NET_RD_A             16'ha419
`define BPM_ADDR_NET_WR_A             16'ha794
`define BPM_ADDR_NET_RD_B             16'ha801
`define BPM_ADDR_NET_WR_B             16'hab7c
`define BPM_ADDR_MECH_STATUS          16'hcb3b
`define BPM_ADDR_CLOSE_CMD            16'hcd15
`define BPM_ADDR_OPEN_CMD             16'hcd16

// command argument and function code
`define BPM_CMD_VALUE                 16'h0815
`define BPM_FC_WRITE_MULTI            8'h10
`define BPM_FC_WRITE_SINGLE           8'h06

// exception codes
`define BPM_EXC_NONE                  8'h00
`define BPM_EXC_BAD_ADDR              8'h02
`define BPM_EXC_BAD_VALUE             8'h04

// as-delivered values
`define BPM_TCP_PORT_DEFAULT          16'h01f6
`define BPM_ZERO16                    16'h0000

// mechanism status encoding
`define BPM_MECH_IDLE                 16'h0000
`define BPM_MECH_OK                   16'h0001
`define BPM_MECH_FAIL                 16'h0002
`define BPM_MECH_BUSY                 16'h0003

// prewarning adaptation: threshold capped at seven eighths of the overload setting
`define BPM_PREWARN_SHIFT             3

`endif

// ---- core/bpm_prewarn.v ----
`timescale 1ns/100ps
`default_nettype none
`include "bpm_regs_defs.vh"

// overload prewarning: clamps the requested threshold below the active
// overload setting and raises an alarm independent of overload enable
module bpm_prewarn #(
    parameter W = 16
) (
    input  wire         mclk,
    input  wire         rst_b,
    input  wire         loadPrewarn,
    input  wire [W-1:0] prewarnRequest,
    input  wire [W-1:0] overloadSetting,
    input  wire [W-1:0] loadCurrent,
    output reg  [W-1:0] prewarnThreshold,
    output reg          prewarnAlarm
);
    wire [W-1:0] maxThreshold;
    assign maxThreshold = overloadSetting - (overloadSetting >> `BPM_PREWARN_SHIFT);

    always @(posedge mclk)
    begin
        if (!rst_b)
        begin
            prewarnThreshold <= {W{1'b0}};
            prewarnAlarm     <= 1'b0;
        end
        else
        begin
            // R08 adapt to overload
            if (loadPrewarn)
                prewarnThreshold <= (prewarnRequest > maxThreshold) ? maxThreshold : prewarnRequest;
            // R10 alarm, never trip
            // R11 works with overload off
            prewarnAlarm <= (prewarnThreshold != {W{1'b0}}) && (loadCurrent >= prewarnThreshold);
        end
    end
endmodule
`default_nettype wire

// ---- core/bpm_param_map.v ----
`timescale 1ns/100ps
`default_nettype none
`include "bpm_regs_defs.vh"

// Overview of operation
// R01 - effective set A values are read-only
// R02 - set A electronic-setting registers read/write
// R03 - intermittent detection per set read/write
// R04 - set B short-time registers read/write
// R05 - value 0815 to close/open command registers
// R06 - switching only while remote lock off
// R07 - mechanism status reports last switch result
// R08 - prewarning adapted to active overload setting
// R09 - client sends overload before prewarning
// R10 - prewarning raises alarm, never trips
// R11 - prewarning works with overload off
// R12 - network params readable per module role
// R13 - network params written only by 0x10
// R14 - tcp port data point defaults 502
// R15 - locked switching answers exception 04
// R16 - writes to read-only registers rejected
module bpm_param_map #(
    parameter W = 16
) (
    input  wire         mclk,
    input  wire         rst_b,
    // decoded request from the protocol engine
    input  wire         reqValid,
    input  wire         reqWrite,
    input  wire [7:0]   reqFunc,
    input  wire [15:0]  reqAddr,
    input  wire [W-1:0] reqData,
    output reg          rspValid,
    output reg  [W-1:0] rspData,
    output reg  [7:0]   rspException,
    // trip unit side
    input  wire         rotaryAtEset,
    input  wire [W-1:0] rotaryShortDelay,
    input  wire [W-1:0] rotaryEnergyCurve,
    input  wire         moduleRoleB,
    input  wire         remoteSwitchLock,
    input  wire         breakerClosed,
    input  wire         switchDone,
    input  wire         switchFailed,
    output reg          closeCoilPulse,
    output reg          openCoilPulse,
    // overload and prewarning
    input  wire         overloadWrite,
    input  wire         prewarnWrite,
    input  wire [W-1:0] loadCurrent,
    output reg  [W-1:0] overloadSetting,
    output wire [W-1:0] prewarnThreshold,
    output wire         prewarnAlarm,
    // network parameters
    output reg  [W-1:0] netParams,
    output reg  [W-1:0] tcpPort,
    output reg          netParamsUpdate
);
    localparam ST_IDLE = 3'b001;
    localparam ST_WAIT = 3'b010;
    localparam ST_DONE = 3'b100;

    reg [W-1:0] intermitA;
    reg [W-1:0] shortDelayEsetA;
    reg [W-1:0] energyCurveEsetA;
    reg [W-1:0] shortTripEsetA;
    reg [W-1:0] shortDelayB;
    reg [W-1:0] energyCurveB;
    reg [W-1:0] shortTripB;
    reg [W-1:0] intermitB;
    reg [W-1:0] mechStatus;
    reg [2:0]   switchState;
    reg [2:0]   next_switchState;
    // direction of the running command, checked against the contacts at done
    reg         closing;

    // read-only view of effective values, status or network parameters
    function isReadOnly;
        input [15:0] a;
        begin
            isReadOnly = (a == `BPM_ADDR_SHORT_DELAY_EFF_A) || (a == `BPM_ADDR_ENERGY_CURVE_EFF_A) ||
                         (a == `BPM_ADDR_SHORT_TRIP_EFF) || (a == `BPM_ADDR_MECH_STATUS) ||
                         (a == `BPM_ADDR_NET_RD_A) || (a == `BPM_ADDR_NET_RD_B);
        end
    endfunction

    function isCommand;
        input [15:0] a;
        begin
            isCommand = (a == `BPM_ADDR_CLOSE_CMD) || (a == `BPM_ADDR_OPEN_CMD);
        end
    endfunction

    function isNetWrite;
        input [15:0] a;
        input        roleB;
        begin
            isNetWrite = roleB ? (a == `BPM_ADDR_NET_WR_B) : (a == `BPM_ADDR_NET_WR_A);
        end
    endfunction

    // effective value: electronic setting when the rotary sits at e-setting
    function [W-1:0] effective;
        input          useEset;
        input [W-1:0]  esetVal;
        input [W-1:0]  rotaryVal;
        begin
            effective = useEset ? esetVal : rotaryVal;
        end
    endfunction

    // reqWrite only qualifies a valid request
    wire wrReq;
    wire rdReq;
    assign wrReq = reqValid && reqWrite;
    assign rdReq = reqValid && !reqWrite;

    // write acceptance and error classification
    reg [7:0] wrExc;
    reg       wrRw;
    always @*
    begin
        wrRw = 1'b0;
        case (reqAddr)
            `BPM_ADDR_INTERMIT_A, `BPM_ADDR_SHORT_DELAY_ESET_A, `BPM_ADDR_ENERGY_CURVE_ESET_A,
            `BPM_ADDR_SHORT_TRIP_ESET_A, `BPM_ADDR_SHORT_DELAY_B, `BPM_ADDR_ENERGY_CURVE_B,
            `BPM_ADDR_SHORT_TRIP_B, `BPM_ADDR_INTERMIT_B:
                wrRw = 1'b1;
            default:
                wrRw = 1'b0;
        endcase
        wrExc = `BPM_EXC_NONE;
        // R16 read-only rejected
        if (isReadOnly(reqAddr))
            wrExc = `BPM_EXC_BAD_VALUE;
        else if (isCommand(reqAddr))
        begin
            // R05 only 0815 accepted
            if (reqData != `BPM_CMD_VALUE)
                wrExc = `BPM_EXC_BAD_VALUE;
            // R15 locked switching refused
            else if (remoteSwitchLock)
                wrExc = `BPM_EXC_BAD_VALUE;
            // a command while one is running counts as busy
            else if (switchState != ST_IDLE)
                wrExc = `BPM_EXC_BAD_VALUE;
        end
        else if (isNetWrite(reqAddr, moduleRoleB))
        begin
            // R13 multi-register write only
            if (reqFunc != `BPM_FC_WRITE_MULTI)
                wrExc = `BPM_EXC_BAD_VALUE;
        end
        else if (!wrRw)
            wrExc = `BPM_EXC_BAD_ADDR;
    end

    // a refused write leaves every register untouched
    wire wrOk;
    assign wrOk = wrReq && (wrExc == `BPM_EXC_NONE);

    // read mux
    reg [W-1:0] rdVal;
    reg [7:0]   rdExc;
    always @*
    begin
        rdVal = `BPM_ZERO16;
        rdExc = `BPM_EXC_NONE;
        case (reqAddr)
            // R01 effective short delay and energy curve follow rotary or eset; short trip always reads eset
            `BPM_ADDR_SHORT_DELAY_EFF_A:  rdVal = effective(rotaryAtEset, shortDelayEsetA, rotaryShortDelay);
            `BPM_ADDR_ENERGY_CURVE_EFF_A: rdVal = effective(rotaryAtEset, energyCurveEsetA, rotaryEnergyCurve);
            `BPM_ADDR_SHORT_TRIP_EFF:     rdVal = shortTripEsetA;
            // R02 set A eset readback
            `BPM_ADDR_SHORT_DELAY_ESET_A:  rdVal = shortDelayEsetA;
            `BPM_ADDR_ENERGY_CURVE_ESET_A: rdVal = energyCurveEsetA;
            `BPM_ADDR_SHORT_TRIP_ESET_A:   rdVal = shortTripEsetA;
            // R03 intermittent detection
            `BPM_ADDR_INTERMIT_A: rdVal = intermitA;
            `BPM_ADDR_INTERMIT_B: rdVal = intermitB;
            // R04 set B readback
            `BPM_ADDR_SHORT_DELAY_B:  rdVal = shortDelayB;
            `BPM_ADDR_ENERGY_CURVE_B: rdVal = energyCurveB;
            `BPM_ADDR_SHORT_TRIP_B:   rdVal = shortTripB;
            // R07 switch result
            `BPM_ADDR_MECH_STATUS: rdVal = mechStatus;
            // R12 role-dependent address
            `BPM_ADDR_NET_RD_A:
            begin
                rdVal = netParams;
                if (moduleRoleB)
                    rdExc = `BPM_EXC_BAD_ADDR;
            end
            `BPM_ADDR_NET_RD_B:
            begin
                rdVal = netParams;
                if (!moduleRoleB)
                    rdExc = `BPM_EXC_BAD_ADDR;
            end
            // gaps and write-only commands read as bad address
            default: rdExc = `BPM_EXC_BAD_ADDR;
        endcase
    end

    // response register: one cycle after the request
    always @(posedge mclk)
    begin
        if (!rst_b)
        begin
            rspValid     <= 1'b0;
            rspData      <= `BPM_ZERO16;
            rspException <= `BPM_EXC_NONE;
        end
        else
        begin
            rspValid     <= reqValid;
            // refused reads answer zero so nothing stale leaks out
            rspData      <= (rdReq && rdExc == `BPM_EXC_NONE) ? rdVal : `BPM_ZERO16;
            // exception answers reads and writes alike
            rspException <= rdReq ? rdExc : (wrReq ? wrExc : `BPM_EXC_NONE);
        end
    end

    // parameter storage
    always @(posedge mclk)
    begin
        if (!rst_b)
        begin
            intermitA        <= `BPM_ZERO16;
            shortDelayEsetA  <= `BPM_ZERO16;
            energyCurveEsetA <= `BPM_ZERO16;
            shortTripEsetA   <= `BPM_ZERO16;
            shortDelayB      <= `BPM_ZERO16;
            energyCurveB     <= `BPM_ZERO16;
            shortTripB       <= `BPM_ZERO16;
            intermitB        <= `BPM_ZERO16;
            netParams        <= `BPM_ZERO16;
            // no write path yet: port stays at its delivered value
            // R14 as-delivered port
            tcpPort          <= `BPM_TCP_PORT_DEFAULT;
            netParamsUpdate  <= 1'b0;
            overloadSetting  <= `BPM_ZERO16;
        end
        else
        begin
            // update strobe lasts one cycle
            netParamsUpdate <= 1'b0;
            // prewarning clamps against this setting
            if (overloadWrite)
                overloadSetting <= reqData;
            if (wrOk)
            begin
                case (reqAddr)
                    // R02 eset writes
                    `BPM_ADDR_SHORT_DELAY_ESET_A:  shortDelayEsetA  <= reqData;
                    `BPM_ADDR_ENERGY_CURVE_ESET_A: energyCurveEsetA <= reqData;
                    `BPM_ADDR_SHORT_TRIP_ESET_A:   shortTripEsetA   <= reqData;
                    // R03 detection writes
                    `BPM_ADDR_INTERMIT_A: intermitA <= reqData;
                    `BPM_ADDR_INTERMIT_B: intermitB <= reqData;
                    // R04 set B writes
                    `BPM_ADDR_SHORT_DELAY_B:  shortDelayB  <= reqData;
                    `BPM_ADDR_ENERGY_CURVE_B: energyCurveB <= reqData;
                    `BPM_ADDR_SHORT_TRIP_B:   shortTripB   <= reqData;
                    // R13 net command accepted
                    `BPM_ADDR_NET_WR_A, `BPM_ADDR_NET_WR_B:
                    begin
                        netParams       <= reqData;
                        netParamsUpdate <= 1'b1;
                    end
                    default:
                    begin
                    end
                endcase
            end
        end
    end

    // switching sequencer
    wire cmdClose;
    wire cmdOpen;
    // lock already refused in wrExc; kept so coils never fire locked
    // R06 lock gates commands
    assign cmdClose = wrOk && (reqAddr == `BPM_ADDR_CLOSE_CMD) && !remoteSwitchLock;
    assign cmdOpen  = wrOk && (reqAddr == `BPM_ADDR_OPEN_CMD) && !remoteSwitchLock;

    always @*
    begin
        case (switchState)
            ST_IDLE: next_switchState = (cmdClose || cmdOpen) ? ST_WAIT : ST_IDLE;
            ST_WAIT: next_switchState = (switchDone || switchFailed) ? ST_DONE : ST_WAIT;
            // one spare cycle between finished and next command
            ST_DONE: next_switchState = ST_IDLE;
            default: next_switchState = ST_IDLE;
        endcase
    end

    always @(posedge mclk)
    begin
        if (!rst_b)
        begin
            switchState    <= ST_IDLE;
            closeCoilPulse <= 1'b0;
            openCoilPulse  <= 1'b0;
            mechStatus     <= `BPM_MECH_IDLE;
            closing        <= 1'b0;
        end
        else
        begin
            switchState <= next_switchState;
            // R05 act on command
            closeCoilPulse <= cmdClose;
            openCoilPulse  <= cmdOpen;
            // R07 record outcome
            if (cmdClose || cmdOpen)
            begin
                mechStatus <= `BPM_MECH_BUSY;
                closing    <= cmdClose;
            end
            else if (switchState == ST_WAIT && switchFailed)
                mechStatus <= `BPM_MECH_FAIL;
            // done while the contacts disagree with the command is a failure
            else if (switchState == ST_WAIT && switchDone)
                mechStatus <= (breakerClosed == closing) ? `BPM_MECH_OK : `BPM_MECH_FAIL;
        end
    end

    // R09 overload first, then prewarning; clamping uses current setting
    // same-cycle loads clamp against the old setting
    bpm_prewarn #(
        .W(W)
    ) uPrewarn (
        .mclk             (mclk),
        .rst_b            (rst_b),
        .loadPrewarn      (prewarnWrite),
        .prewarnRequest   (reqData),
        .overloadSetting  (overloadSetting),
        .loadCurrent      (loadCurrent),
        .prewarnThreshold (prewarnThreshold),
        .prewarnAlarm     (prewarnAlarm)
    );
endmodule
`default_nettype wire

// ---- verif/bpm_param_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none
module bpm_param_monitor #(
    parameter W = 16
) (
    input wire logic         mclk,
    input wire logic         rst_b,
    input wire logic         reqValid,
    input wire logic         reqWrite,
    input wire logic [7:0]   reqFunc,
    input wire logic [15:0]  reqAddr,
    input wire logic [W-1:0] reqData,
    input wire logic         rspValid,
    input wire logic [7:0]   rspException,
    input wire logic         moduleRoleB,
    input wire logic         remoteSwitchLock,
    input wire logic         closeCoilPulse,
    input wire logic         openCoilPulse,
    input wire logic [W-1:0] loadCurrent,
    input wire logic [W-1:0] prewarnThreshold,
    input wire logic         prewarnAlarm,
    input wire logic [W-1:0] tcpPort,
    input wire logic         netParamsUpdate
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    wire wr = reqValid && reqWrite;
    wire cmdOk = wr && reqData == 16'h0815 && !remoteSwitchLock;
    ro_reject_a:
        assert property (wr && reqAddr inside {16'h1f42, 16'h1f44, 16'h1f45} |=> rspValid && rspException == 8'h04)
        else $error("read-only write accepted");
    close_cause_a:
        assert property (closeCoilPulse |-> $past(cmdOk && reqAddr == 16'hcd15))
        else $error("close pulse without command");
    open_cause_a:
        assert property (openCoilPulse |-> $past(cmdOk && reqAddr == 16'hcd16))
        else $error("open pulse without command");
    lock_refuse_a:
        assert property (wr && remoteSwitchLock && reqAddr inside {16'hcd15, 16'hcd16}
            |=> rspException == 8'h04 && !closeCoilPulse && !openCoilPulse)
        else $error("locked switching not refused");
    net_write_a:
        assert property (netParamsUpdate |-> $past(wr && reqFunc == 8'h10 && reqAddr inside {16'ha794, 16'hab7c}))
        else $error("net update without multi write");
    net_read_a:
        assert property (reqValid && !reqWrite && reqAddr == (moduleRoleB ? 16'ha801 : 16'ha419)
            |=> rspValid && rspException == 8'h00)
        else $error("net read refused");
    port_default_a:
        assert property ($rose(rst_b) |-> tcpPort == 16'h01f6)
        else $error("tcp port not default after reset");
    alarm_set_a:
        assert property ((prewarnThreshold != 0 && loadCurrent >= prewarnThreshold) [*2] |-> prewarnAlarm)
        else $error("prewarn alarm missing");
    alarm_clear_a:
        assert property ((loadCurrent < prewarnThreshold) [*2] |-> !prewarnAlarm)
        else $error("prewarn alarm without cause");
endmodule
`default_nettype wire

// ---- verif/bpm_client.sv ----
`timescale 1ns/100ps
`default_nettype none
module bpm_client (
    input wire logic        mclk,
    output var logic        reqValid,
    output var logic        reqWrite,
    output var logic [7:0]  reqFunc,
    output var logic [15:0] reqAddr,
    output var logic [15:0] reqData,
    output var logic        overloadWrite,
    output var logic        prewarnWrite,
    input wire logic        rspValid,
    input wire logic [15:0] rspData,
    input wire logic [7:0]  rspException
);
    initial
    begin
        {reqValid, reqWrite, overloadWrite, prewarnWrite} = 4'h0;
        {reqFunc, reqAddr, reqData} = 40'h0;
    end
    task automatic xfer(input logic w, input logic [7:0] f, input logic [15:0] a, d,
                        output logic [15:0] q, output logic [7:0] x);
        @(posedge mclk);
        #1;
        {reqValid, reqWrite, reqFunc, reqAddr, reqData} = {1'b1, w, f, a, d};
        @(posedge mclk);
        #1;
        reqValid = 1'b0;
        // released lines must not keep the old value
        {reqAddr, reqData} = ~{a, d};
        q = rspData;
        x = rspValid ? rspException : 8'hff;
    endtask
    task automatic loadLimits(input logic [15:0] ov, pw);
        @(posedge mclk);
        #1;
        {reqData, overloadWrite} = {ov, 1'b1};
        @(posedge mclk);
        #1;
        {reqData, overloadWrite, prewarnWrite} = {pw, 2'b01};
        @(posedge mclk);
        #1;
        {reqData, prewarnWrite} = {~pw, 1'b0};
    endtask
endmodule
`default_nettype wire

// ---- verif/bpm_param_map_test.sv ----
`timescale 1ns/100ps
`default_nettype none
module bpm_param_map_test;
    logic        mclk, rst_b, rotaryAtEset, moduleRoleB, remoteSwitchLock, switchDone, switchFailed, breakerClosed;
    logic [15:0] rotaryShortDelay, rotaryEnergyCurve, loadCurrent, q, v, ov;
    logic [15:0] mem [8];
    logic [15:0] rwAddr [8] = '{16'h1f48, 16'h1f4a, 16'h1f4c, 16'h1f4d, 16'h1f50, 16'h1f52, 16'h1f53, 16'h1f54};
    logic [15:0] effAddr [3] = '{16'h1f42, 16'h1f44, 16'h1f45};
    logic [7:0]  e;
    int          fail_count, check_count;
    wire         reqValid, reqWrite, rspValid, overloadWrite, prewarnWrite;
    wire         closeCoilPulse, openCoilPulse, prewarnAlarm, netParamsUpdate;
    wire [7:0]   reqFunc, rspException;
    wire [15:0]  reqAddr, reqData, rspData, overloadSetting, prewarnThreshold, netParams, tcpPort;
    bpm_param_map #(.W(16)) DUT (.mclk, .rst_b, .reqValid, .reqWrite, .reqFunc, .reqAddr, .reqData,
        .rspValid, .rspData, .rspException, .rotaryAtEset, .rotaryShortDelay, .rotaryEnergyCurve,
        .moduleRoleB, .remoteSwitchLock, .breakerClosed, .switchDone, .switchFailed,
        .closeCoilPulse, .openCoilPulse, .overloadWrite, .prewarnWrite, .loadCurrent, .overloadSetting,
        .prewarnThreshold, .prewarnAlarm, .netParams, .tcpPort, .netParamsUpdate);
    bpm_client cli (.mclk, .reqValid, .reqWrite, .reqFunc, .reqAddr, .reqData, .overloadWrite,
        .prewarnWrite, .rspValid, .rspData, .rspException);
    always #25 mclk = ~mclk;
    task automatic chkVal(input logic [15:0] got, exp);
        check_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkExc(input logic [7:0] got, exp);
        check_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR %0t exception %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rw(input logic w, input logic [7:0] f, input logic [15:0] a, d);
        cli.xfer(w, f, a, d, q, e);
    endtask
    task automatic tick;
        @(posedge mclk);
        #1;
    endtask
    function automatic logic [15:0] effVal(input int i);
        if (i == 2)
            return mem[3];
        if (!rotaryAtEset)
            return i ? rotaryEnergyCurve : rotaryShortDelay;
        return mem[i + 1];
    endfunction
    function automatic logic [15:0] thrVal(input logic [15:0] o, p);
        return (p > o - (o >> 3)) ? o - (o >> 3) : p;
    endfunction
    task automatic sw(input logic [15:0] a, d, input logic lk, input logic [7:0] x);
        remoteSwitchLock = lk;
        rw(1'b1, 8'h06, a, d);
        remoteSwitchLock = 1'b0;
        chkExc(e, x);
        chkVal({closeCoilPulse, openCoilPulse}, (x != 0) ? 0 : (a == 16'hcd15) ? 2 : 1);
    endtask
    task automatic settle(input logic f, c, input logic [15:0] x);
        {switchDone, switchFailed, breakerClosed} = {1'b1, f, c};
        tick;
        {switchDone, switchFailed} = 2'b00;
        rw(1'b0, 8'h03, 16'hcb3b, 16'h0);
        chkVal(q, x);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        $display("ERROR %0t run timed out", $time);
        complete_run;
    end
    initial
    begin
        {mclk, rst_b, rotaryAtEset, moduleRoleB, remoteSwitchLock, switchDone, switchFailed, breakerClosed} = 8'h00;
        fail_count = 0;
        check_count = 0;
        loadCurrent = 16'h0;
        void'($urandom(32'hab790163));
        rotaryShortDelay = 16'($urandom);
        rotaryEnergyCurve = 16'($urandom);
        repeat (12) @(posedge mclk);
        #1;
        rst_b = 1'b1;
        chkVal(tcpPort, 16'h01f6);
        $display("reset test done");
        foreach (rwAddr[i])
        begin
            mem[i] = 16'($urandom);
            rw(1'b1, 8'h06, rwAddr[i], mem[i]);
            chkExc(e, 8'h00);
        end
        foreach (rwAddr[i])
        begin
            rw(1'b0, 8'h03, rwAddr[i], 16'h0);
            chkVal(q, mem[i]);
        end
        $display("read write test done");
        for (int k = 0; k < 2; k++)
        begin
            rotaryAtEset = k[0];
            for (int i = 0; i < 3; i++)
            begin
                rw(1'b1, 8'h06, effAddr[i], 16'($urandom));
                chkExc(e, 8'h04);
                rw(1'b0, 8'h03, effAddr[i], 16'h0);
                chkVal(q, effVal(i));
            end
        end
        $display("effective value test done");
        sw(16'hcd15, 16'h0815, 1'b0, 8'h00);
        rw(1'b0, 8'h03, 16'hcb3b, 16'h0);
        chkVal(q, 16'h0003);
        // busy mechanism refuses a second command
        sw(16'hcd16, 16'h0815, 1'b0, 8'h04);
        settle(1'b0, 1'b1, 16'h0001);
        sw(16'hcd16, 16'h0816, 1'b0, 8'h04);
        sw(16'hcd16, 16'h0815, 1'b1, 8'h04);
        sw(16'hcd15, 16'h0815, 1'b1, 8'h04);
        sw(16'hcd16, 16'h0815, 1'b0, 8'h00);
        settle(1'b1, 1'b0, 16'h0002);
        // contacts stay open after a close: reported as failed
        sw(16'hcd15, 16'h0815, 1'b0, 8'h00);
        settle(1'b0, 1'b0, 16'h0002);
        $display("switching test done");
        for (int k = 0; k < 2; k++)
        begin
            moduleRoleB = k[0];
            v = 16'($urandom);
            rw(1'b1, 8'h06, k ? 16'hab7c : 16'ha794, v);
            chkExc(e, 8'h04);
            rw(1'b1, 8'h10, k ? 16'hab7c : 16'ha794, v);
            chkVal({15'h0, netParamsUpdate}, 16'h0001);
            chkVal(netParams, v);
            rw(1'b1, 8'h10, k ? 16'ha794 : 16'hab7c, ~v);
            chkExc(e, 8'h02);
            chkVal(netParams, v);
            rw(1'b0, 8'h03, k ? 16'ha801 : 16'ha419, 16'h0);
            chkVal(q, v);
            rw(1'b0, 8'h03, k ? 16'ha419 : 16'ha801, 16'h0);
            chkExc(e, 8'h02);
        end
        $display("network test done");
        for (int k = 0; k < 3; k++)
        begin
            ov = (k == 0) ? 16'h0008 : 16'($urandom_range(16'hfff0, 16'h0100));
            v = (k == 1) ? 16'hffff : 16'($urandom_range(ov, 1));
            cli.loadLimits(ov, v);
            chkVal(overloadSetting, ov);
            tick;
            chkVal(prewarnThreshold, thrVal(ov, v));
            loadCurrent = thrVal(ov, v);
            repeat (2) tick;
            chkVal({15'h0, prewarnAlarm}, 16'h0001);
            loadCurrent = thrVal(ov, v) - 16'h1;
            repeat (2) tick;
            chkVal({15'h0, prewarnAlarm}, 16'h0000);
        end
        $display("prewarning test done");
        rst_b = 1'b0;
        repeat (2) tick;
        rst_b = 1'b1;
        chkVal(tcpPort, 16'h01f6);
        $display("second reset test done");
        complete_run;
    end
endmodule
bind bpm_param_map bpm_param_monitor #(.W(W)) mon (.mclk, .rst_b, .reqValid, .reqWrite, .reqFunc, .reqAddr,
    .reqData, .rspValid, .rspException, .moduleRoleB, .remoteSwitchLock, .closeCoilPulse, .openCoilPulse,
    .loadCurrent, .prewarnThreshold, .prewarnAlarm, .tcpPort, .netParamsUpdate);
`default_nettype wire
